/* File: rtl/rsb_status_bank.sv */
// Recorder status bank: four status groups, per-connection filters,
// query snapshot and decimal text reply "ddd.ccc.bbb.aaa".
// Assumes all inputs synchronous to clk; event inputs are one-cycle
// pulses, condition inputs are levels.
// Refused queries leave every output unchanged.
module rsb_status_bank #(
   parameter int N_CONN = 2,
   parameter int CW     = 1
) (
   input  wire logic          clk,
   input  wire logic          rst,
   // Events, one-cycle pulses
   input  wire logic          ad_done,
   input  wire logic          print_timer_exp,
   input  wire logic          timed_log_exp,
   input  wire logic          meas_drop,
   input  wire logic          unit_change,
   input  wire logic          cmd_syntax_err,
   input  wire logic          cmd_exec_err,
   // Conditions, levels
   input  wire logic          out_of_paper,
   input  wire logic          feed_key_active,
   input  wire logic          basic_setting,
   input  wire logic          recording,
   input  wire logic          computing,
   input  wire logic          alarm_active,
   input  wire logic          header_printing,
   // Filter write
   input  wire logic          filter_we,
   input  wire logic [CW-1:0] filter_conn,
   input  wire logic [1:0]    filter_sel,
   input  wire logic [7:0]    filter_data,
   // Status query
   input  wire logic          status_query_command,
   input  wire logic [CW-1:0] query_conn,
   output logic               query_busy,
   output logic      [7:0]    status_g1,
   output logic      [7:0]    status_g2,
   output logic      [7:0]    status_g3,
   output logic      [7:0]    status_g4,
   // Reply text stream
   output logic      [7:0]    reply_char,
   output logic               reply_valid,
   output logic               reply_last,
   input  wire logic          reply_ready
);

   typedef struct packed {
      rsb_pkg::rsb_state_e state;
      logic [3:0]          idx;
      logic [7:0]          g1;
      logic [7:0]          g2;
      logic [7:0]          g3;
      logic [7:0]          g4;
      logic [7:0]          ch;
      logic                valid;
      logic                last;
      logic                busy;
   } rsb_main_s;

   rsb_main_s m_reg;
   rsb_main_s m_next;

   // Event set vectors
   logic [7:0] ev1;
   logic [7:0] ev2;
   // Live condition vectors
   logic [7:0] live3;
   logic [7:0] live4;

   // Per-connection slice ports
   logic [7:0] lat1_a  [N_CONN];
   logic [7:0] lat2_a  [N_CONN];
   logic [7:0] filt1_a [N_CONN];
   logic [7:0] filt2_a [N_CONN];
   logic [7:0] filt3_a [N_CONN];
   logic [7:0] filt4_a [N_CONN];
   logic       clr_a   [N_CONN];
   logic       fwe_a   [N_CONN];

   // Filtered groups of every connection
   logic [7:0] view1_a [N_CONN];
   logic [7:0] view2_a [N_CONN];
   logic [7:0] view3_a [N_CONN];
   logic [7:0] view4_a [N_CONN];

   // Groups of the queried connection
   logic [7:0] snap1;
   logic [7:0] snap2;
   logic [7:0] snap3;
   logic [7:0] snap4;

   // Connection indices in range
   logic       qconn_ok;
   logic       fconn_ok;

   logic       accept;

   // Decimal digit or period of one group value
   function automatic logic [7:0] rsb_char(
      input logic [7:0] v,
      input logic [1:0] pos
   );
      logic [7:0] d;
      logic [7:0] hund;
      logic [7:0] tens;
      logic [7:0] ones;
      d    = 8'h00;
      hund = v / rsb_pkg::DEC_HUND;
      tens = (v / rsb_pkg::DEC_TEN) % rsb_pkg::DEC_TEN;
      ones = v % rsb_pkg::DEC_TEN;
      if (pos == rsb_pkg::DOT_POS) begin
         d = rsb_pkg::ASCII_DOT;
      end else if (pos == rsb_pkg::POS_HUND) begin
         d = rsb_pkg::ASCII_ZERO + hund;
      end else if (pos == rsb_pkg::POS_TENS) begin
         d = rsb_pkg::ASCII_ZERO + tens;
      end else begin
         d = rsb_pkg::ASCII_ZERO + ones;
      end
      return d;
   endfunction : rsb_char

   // Group 1 events
   always_comb begin
      ev1 = 8'h00;
      ev1[rsb_pkg::G1_AD_DONE]   = ad_done;
      ev1[rsb_pkg::G1_PRINT_TMO] = print_timer_exp;
      ev1[rsb_pkg::G1_TIMED_LOG] = timed_log_exp;
      ev1 = ev1 & rsb_pkg::G1_USED;
   end

   // Group 2 events
   always_comb begin
      ev2 = 8'h00;
      ev2[rsb_pkg::G2_MEAS_DROP] = meas_drop;
      ev2[rsb_pkg::G2_UNIT_CHG]  = unit_change;
      ev2[rsb_pkg::G2_CMD_ERR]   = cmd_syntax_err;
      ev2[rsb_pkg::G2_EXEC_ERR]  = cmd_exec_err;
      ev2 = ev2 & rsb_pkg::G2_USED;
   end

   // Group 3 live conditions
   always_comb begin
      live3 = 8'h00;
      live3[rsb_pkg::G3_CHART_END]  = out_of_paper;
      live3[rsb_pkg::G3_CHART_FEED] = feed_key_active;
      live3 = live3 & rsb_pkg::G3_USED;
   end

   // Group 4 live conditions
   always_comb begin
      live4 = 8'h00;
      live4[rsb_pkg::G4_BASIC]   = basic_setting;
      live4[rsb_pkg::G4_RECORD]  = recording;
      live4[rsb_pkg::G4_COMPUTE] = computing;
      live4[rsb_pkg::G4_ALARM]   = alarm_active;
      live4[rsb_pkg::G4_HEADER]  = header_printing;
      live4 = live4 & rsb_pkg::G4_USED;
   end

   // Indices past the last connection are ignored
   assign qconn_ok = int'(query_conn) < N_CONN;
   assign fconn_ok = int'(filter_conn) < N_CONN;

   // Refused while a reply is still going out
   assign accept = status_query_command
                   && (m_reg.state == rsb_pkg::RSB_IDLE)
                   && qconn_ok;

   // Held groups of the queried connection clear at accept
   always_comb begin
      for (int i = 0; i < N_CONN; i++) begin
         clr_a[i] = accept && (int'(query_conn) == i);
      end
   end

   // Filter write to the addressed connection only
   always_comb begin
      for (int i = 0; i < N_CONN; i++) begin
         fwe_a[i] = filter_we && fconn_ok
                    && (int'(filter_conn) == i);
      end
   end

   // One slice per host connection
   generate
      for (genvar c = 0; c < N_CONN; c++) begin : g_conn
         rsb_conn_slice #(
            .W (rsb_pkg::GRP_W)
         ) u_slice (
            .clk    (clk),
            .rst    (rst),
            .set1   (ev1),
            .set2   (ev2),
            .clr    (clr_a[c]),
            .f_we   (fwe_a[c]),
            .f_sel  (filter_sel),
            .f_data (filter_data),
            .lat1   (lat1_a[c]),
            .lat2   (lat2_a[c]),
            .filt1  (filt1_a[c]),
            .filt2  (filt2_a[c]),
            .filt3  (filt3_a[c]),
            .filt4  (filt4_a[c])
         );
      end
   endgenerate

   // Condition AND filter per connection
   always_comb begin
      for (int i = 0; i < N_CONN; i++) begin
         view1_a[i] = lat1_a[i] & filt1_a[i] & rsb_pkg::G1_USED;
         view2_a[i] = lat2_a[i] & filt2_a[i] & rsb_pkg::G2_USED;
         view3_a[i] = live3 & filt3_a[i] & rsb_pkg::G3_USED;
         view4_a[i] = live4 & filt4_a[i] & rsb_pkg::G4_USED;
      end
   end

   // Pick the queried connection
   always_comb begin
      snap1 = 8'h00;
      snap2 = 8'h00;
      snap3 = 8'h00;
      snap4 = 8'h00;
      for (int i = 0; i < N_CONN; i++) begin
         if (int'(query_conn) == i) begin
            snap1 = view1_a[i];
            snap2 = view2_a[i];
            snap3 = view3_a[i];
            snap4 = view4_a[i];
         end
      end
   end

   // Snapshot, then text reply
   always_comb begin
      logic [7:0] val;
      logic [1:0] grp;
      val    = 8'h00;
      grp    = 2'h0;
      m_next = m_reg;
      case (m_reg.state)
         rsb_pkg::RSB_IDLE: begin
            // Nothing offered while idle
            m_next.valid = 1'b0;
            m_next.last  = 1'b0;
            if (accept) begin
               m_next.idx   = 4'h0;
               m_next.busy  = 1'b1;
               m_next.state = rsb_pkg::RSB_SEND;
               // All four groups captured together
               m_next.g1    = snap1;
               m_next.g2    = snap2;
               m_next.g3    = snap3;
               m_next.g4    = snap4;
            end
         end
         rsb_pkg::RSB_SEND: begin
            // Offered char holds until the host takes it
            if (!m_reg.valid || reply_ready) begin
               // Last char taken, link released
               if (m_reg.valid && m_reg.last) begin
                  m_next.valid = 1'b0;
                  m_next.last  = 1'b0;
                  m_next.busy  = 1'b0;
                  m_next.state = rsb_pkg::RSB_IDLE;
               end else begin
                  // Group order 4, 3, 2, 1
                  grp = m_reg.idx[3:2];
                  if (grp == 2'h0) begin
                     val = m_reg.g4;
                  end else if (grp == 2'h1) begin
                     val = m_reg.g3;
                  end else if (grp == 2'h2) begin
                     val = m_reg.g2;
                  end else begin
                     val = m_reg.g1;
                  end
                  m_next.ch    = rsb_char(val, m_reg.idx[1:0]);
                  m_next.valid = 1'b1;
                  m_next.last  = (m_reg.idx == rsb_pkg::LAST_IDX);
                  m_next.idx   = m_reg.idx + 4'h1;
               end
            end
         end
         // Unused state code falls back to idle
         default: begin
            m_next.state = rsb_pkg::RSB_IDLE;
         end
      endcase
   end

   // Synchronous reset back to idle
   always_ff @(posedge clk) begin
      if (rst) begin
         m_reg.state <= rsb_pkg::RSB_IDLE;
         m_reg.idx   <= 4'h0;
         m_reg.g1    <= rsb_pkg::COND_RST;
         m_reg.g2    <= rsb_pkg::COND_RST;
         m_reg.g3    <= rsb_pkg::COND_RST;
         m_reg.g4    <= rsb_pkg::COND_RST;
         m_reg.ch    <= 8'h00;
         m_reg.valid <= 1'b0;
         m_reg.last  <= 1'b0;
         m_reg.busy  <= 1'b0;
      end else begin
         m_reg <= m_next;
      end
   end

   // Outputs straight from the state register
   assign query_busy  = m_reg.busy;
   assign status_g1   = m_reg.g1;
   assign status_g2   = m_reg.g2;
   assign status_g3   = m_reg.g3;
   assign status_g4   = m_reg.g4;
   assign reply_char  = m_reg.ch;
   assign reply_valid = m_reg.valid;
   assign reply_last  = m_reg.last;

endmodule : rsb_status_bank

/* File: rtl/rsb_pkg.sv */
// Constants, field layout and types for the recorder status bank.
// Assumes one system clock and a synchronous active-high reset.
package rsb_pkg;

   // Group geometry
   localparam int GRP_W  = 8;
   localparam int N_GRP  = 4;

   // Group 1 event bits
   localparam int G1_AD_DONE   = 0;
   localparam int G1_PRINT_TMO = 2;
   localparam int G1_TIMED_LOG = 3;

   // Group 2 event bits
   localparam int G2_MEAS_DROP = 0;
   localparam int G2_UNIT_CHG  = 1;
   localparam int G2_CMD_ERR   = 2;
   localparam int G2_EXEC_ERR  = 3;

   // Group 3 condition bits
   localparam int G3_CHART_END  = 1;
   localparam int G3_CHART_FEED = 5;

   // Group 4 condition bits
   localparam int G4_BASIC   = 0;
   localparam int G4_RECORD  = 1;
   localparam int G4_COMPUTE = 2;
   localparam int G4_ALARM   = 3;
   localparam int G4_HEADER  = 6;

   // Bits that carry a function in each group
   localparam logic [7:0] G1_USED = 8'h0d;
   localparam logic [7:0] G2_USED = 8'h0f;
   localparam logic [7:0] G3_USED = 8'h22;
   localparam logic [7:0] G4_USED = 8'h4f;

   // Reset values
   localparam logic [7:0] FILTER_RST = 8'hff;
   localparam logic [7:0] COND_RST   = 8'h00;

   // Filter group select codes
   localparam logic [1:0] FSEL_G1 = 2'h0;
   localparam logic [1:0] FSEL_G2 = 2'h1;
   localparam logic [1:0] FSEL_G3 = 2'h2;
   localparam logic [1:0] FSEL_G4 = 2'h3;

   // Reply text
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_DOT  = 8'h2e;
   localparam logic [3:0] LAST_IDX   = 4'he;
   localparam logic [1:0] DOT_POS    = 2'h3;
   localparam logic [1:0] POS_HUND   = 2'h0;
   localparam logic [1:0] POS_TENS   = 2'h1;
   localparam logic [7:0] DEC_HUND   = 8'h64;
   localparam logic [7:0] DEC_TEN    = 8'h0a;

   typedef enum logic [0:0] {
      RSB_IDLE = 1'b0,
      RSB_SEND = 1'b1
   } rsb_state_e;

endpackage : rsb_pkg

/* File: rtl/rsb_conn_slice.sv */
// One connection's filter set and held event groups.
// Assumes set vectors and the clear strobe are synchronous to clk.
module rsb_conn_slice #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] set1,
   input  wire logic [W-1:0] set2,
   input  wire logic         clr,
   input  wire logic         f_we,
   input  wire logic [1:0]   f_sel,
   input  wire logic [W-1:0] f_data,
   output logic      [W-1:0] lat1,
   output logic      [W-1:0] lat2,
   output logic      [W-1:0] filt1,
   output logic      [W-1:0] filt2,
   output logic      [W-1:0] filt3,
   output logic      [W-1:0] filt4
);

   typedef struct packed {
      logic [W-1:0] lat1;
      logic [W-1:0] lat2;
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] f4;
   } rsb_slice_s;

   rsb_slice_s s_reg;
   rsb_slice_s s_next;

   always_comb begin
      s_next = s_reg;
      // Set wins over a clear in the same cycle
      s_next.lat1 = (clr ? W'(rsb_pkg::COND_RST) : s_reg.lat1) | set1;
      s_next.lat2 = (clr ? W'(rsb_pkg::COND_RST) : s_reg.lat2) | set2;
      if (f_we) begin
         if (f_sel == rsb_pkg::FSEL_G1) begin
            s_next.f1 = f_data;
         end else if (f_sel == rsb_pkg::FSEL_G2) begin
            s_next.f2 = f_data;
         end else if (f_sel == rsb_pkg::FSEL_G3) begin
            s_next.f3 = f_data;
         end else begin
            s_next.f4 = f_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg.lat1 <= W'(rsb_pkg::COND_RST);
         s_reg.lat2 <= W'(rsb_pkg::COND_RST);
         s_reg.f1   <= W'(rsb_pkg::FILTER_RST);
         s_reg.f2   <= W'(rsb_pkg::FILTER_RST);
         s_reg.f3   <= W'(rsb_pkg::FILTER_RST);
         s_reg.f4   <= W'(rsb_pkg::FILTER_RST);
      end else begin
         s_reg <= s_next;
      end
   end

   assign lat1  = s_reg.lat1;
   assign lat2  = s_reg.lat2;
   assign filt1 = s_reg.f1;
   assign filt2 = s_reg.f2;
   assign filt3 = s_reg.f3;
   assign filt4 = s_reg.f4;

endmodule : rsb_conn_slice

/* File: dv/rsb_status_bank_properties.sv */
// Checker on the status bank ports: snapshot, busy and reply stream.
// Bound to every rsb_status_bank instance at the foot of this file.
module rsb_status_bank_properties #(
   parameter int N_CONN = 2,
   parameter int CW     = 1
) (
   input wire logic          clk,
   input wire logic          rst,
   input wire logic          out_of_paper,
   input wire logic          feed_key_active,
   input wire logic          basic_setting,
   input wire logic          recording,
   input wire logic          computing,
   input wire logic          alarm_active,
   input wire logic          header_printing,
   input wire logic          status_query_command,
   input wire logic [CW-1:0] query_conn,
   input wire logic          query_busy,
   input wire logic [7:0]    status_g1,
   input wire logic [7:0]    status_g2,
   input wire logic [7:0]    status_g3,
   input wire logic [7:0]    status_g4,
   input wire logic [7:0]    reply_char,
   input wire logic          reply_valid,
   input wire logic          reply_last,
   input wire logic          reply_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       acc;
   logic [7:0] g3_live;
   logic [7:0] g4_live;
   assign acc = status_query_command && !query_busy
                && (int'(query_conn) < N_CONN);
   assign g3_live = {2'h0, feed_key_active, 3'h0, out_of_paper, 1'h0};
   assign g4_live = {1'h0, header_printing, 2'h0, alarm_active,
                     computing, recording, basic_setting};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   busy_on_accept_a: assert property (acc |=> query_busy)
      else $error("busy missing after accept");
   first_char_a: assert property (acc |=> ##1 reply_valid
      && reply_char == 8'h30 + status_g4 / 8'h64)
      else $error("first reply char wrong");
   hold_char_a: assert property (reply_valid && !reply_ready
      |=> reply_valid && $stable(reply_char) && $stable(reply_last))
      else $error("reply char not held");
   last_end_a: assert property (reply_valid && reply_last
      && reply_ready |=> !query_busy && !reply_valid)
      else $error("reply did not end");
   snap_hold_a: assert property (!acc |=>
      $stable({status_g1, status_g2, status_g3, status_g4}))
      else $error("snapshot changed without query");
   g3_live_a: assert property (acc |=>
      (status_g3 & ~$past(g3_live)) == 8'h00)
      else $error("group 3 bit without condition");
   g4_live_a: assert property (acc |=>
      (status_g4 & ~$past(g4_live)) == 8'h00)
      else $error("group 4 bit without condition");
   unused_zero_a: assert property (
      ((status_g1 & ~rsb_pkg::G1_USED) | (status_g2 & ~rsb_pkg::G2_USED)
      | (status_g3 & ~rsb_pkg::G3_USED)
      | (status_g4 & ~rsb_pkg::G4_USED)) == 8'h00)
      else $error("unassigned status bit set");
endmodule : rsb_status_bank_properties

bind rsb_status_bank rsb_status_bank_properties #(
   .N_CONN(N_CONN), .CW(CW)) u_props (
   .clk(clk), .rst(rst), .out_of_paper(out_of_paper),
   .feed_key_active(feed_key_active), .basic_setting(basic_setting),
   .recording(recording), .computing(computing),
   .alarm_active(alarm_active), .header_printing(header_printing),
   .status_query_command(status_query_command),
   .query_conn(query_conn), .query_busy(query_busy),
   .status_g1(status_g1), .status_g2(status_g2), .status_g3(status_g3),
   .status_g4(status_g4), .reply_char(reply_char),
   .reply_valid(reply_valid), .reply_last(reply_last),
   .reply_ready(reply_ready));

/* File: dv/rsb_host_model.sv */
// Host model: issues status queries and collects the reply text.
// Drives on the falling edge; the bank samples on the rising edge.
module rsb_host_model #(
   parameter int CW = 1
) (
   input  wire logic          clk,
   input  wire logic [7:0]    reply_char,
   input  wire logic          reply_valid,
   input  wire logic          reply_last,
   output logic               status_query_command,
   output logic      [CW-1:0] query_conn,
   output logic               reply_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [119:0] cap;
   logic [14:0]  lst;
   initial begin
      status_query_command = 1'b0;
      query_conn = '0;
      reply_ready = 1'b0;
      cap = '0;
      lst = '0;
   end
   // One query; slow stalls the reply two cycles in three
   task automatic ask(input logic [CW-1:0] c, input int slow);
      int i;
      int n;
      i = 0;
      n = 0;
      @(negedge clk);
      status_query_command = 1'b1;
      query_conn = c;
      @(posedge clk);
      @(negedge clk);
      status_query_command = 1'b0;
      query_conn = ~c;
      while (i < 15) begin
         reply_ready = (slow == 0) || (n % 3 == 0);
         n++;
         // Sampled before the edge that takes the char
         if (reply_valid && reply_ready) begin
            cap = {cap[111:0], reply_char};
            lst = {lst[13:0], reply_last};
            i++;
         end
         @(posedge clk);
         @(negedge clk);
      end
      reply_ready = 1'b0;
   endtask : ask
endmodule : rsb_host_model

/* File: dv/rsb_status_bank_test.sv */
// Testbench for the status bank: events, conditions, filters, queries.
// Uses rsb_host_model as the querying host; checker bound separately.
module rsb_status_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, fwe;
   logic [6:0] ev, cnd;
   logic [0:0] fconn;
   logic [1:0] fsel;
   logic [7:0] fdat;
   wire logic       qcmd, bsy, rdy, rvalid, rlast;
   wire logic [0:0] qconn;
   wire logic [7:0] g1, g2, g3, g4, rchar;
   int n_mismatch = 0;
   int compares = 0;
   logic [31:0] emap [7] = '{32'h00020001, 32'h00200004, 32'h01000008,
      32'h02000100, 32'h04000200, 32'h08000400, 32'h40000800};

   rsb_status_bank #(.N_CONN(2), .CW(1)) u_rsb_status_bank (
      .clk(clk), .rst(rst), .ad_done(ev[0]), .print_timer_exp(ev[1]),
      .timed_log_exp(ev[2]), .meas_drop(ev[3]), .unit_change(ev[4]),
      .cmd_syntax_err(ev[5]), .cmd_exec_err(ev[6]),
      .out_of_paper(cnd[0]), .feed_key_active(cnd[1]),
      .basic_setting(cnd[2]), .recording(cnd[3]), .computing(cnd[4]),
      .alarm_active(cnd[5]), .header_printing(cnd[6]),
      .filter_we(fwe), .filter_conn(fconn), .filter_sel(fsel),
      .filter_data(fdat), .status_query_command(qcmd),
      .query_conn(qconn), .query_busy(bsy), .status_g1(g1),
      .status_g2(g2), .status_g3(g3), .status_g4(g4),
      .reply_char(rchar), .reply_valid(rvalid), .reply_last(rlast),
      .reply_ready(rdy));

   rsb_host_model #(.CW(1)) u_rsb_host_model (
      .clk(clk), .reply_char(rchar), .reply_valid(rvalid),
      .reply_last(rlast), .status_query_command(qcmd), .query_conn(qconn),
      .reply_ready(rdy));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [119:0] seen, input logic [119:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Reply text expected for groups {g4,g3,g2,g1}
   function automatic logic [119:0] txt(input logic [31:0] g);
      logic [127:0] t;
      logic [7:0]   v;
      t = '0;
      for (int k = 3; k >= 0; k--) begin
         v = g[8*k +: 8];
         t = {t[95:0], 8'h30 + v / 8'h64, 8'h30 + v / 8'h0a % 8'h0a,
              8'h30 + v % 8'h0a, 8'h2e};
      end
      return t[127:8];
   endfunction : txt

   task automatic q(input logic [0:0] c, input int slow,
                    input logic [31:0] e);
      u_rsb_host_model.ask(c, slow);
      chk({88'h0, g4, g3, g2, g1}, {88'h0, e});
      chk(u_rsb_host_model.cap, txt(e));
      chk({105'h0, u_rsb_host_model.lst}, {105'h0, 15'h0001});
   endtask : q

   task automatic pe(input logic [6:0] v, input logic [6:0] c);
      @(negedge clk);
      ev = v;
      cnd = c;
      @(negedge clk);
      ev = 7'h00;
   endtask : pe

   task automatic fw(input logic [0:0] c, input logic [1:0] s,
                     input logic [7:0] d);
      @(negedge clk);
      fwe = 1'b1;
      fconn = c;
      fsel = s;
      fdat = d;
      @(negedge clk);
      fwe = 1'b0;
   endtask : fw

   task automatic wrap_up;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      ev = 7'h00;
      cnd = 7'h00;
      fwe = 1'b0;
      fconn = 1'b0;
      fsel = 2'h0;
      fdat = 8'h00;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      q(1'b0, 0, 32'h00000000);
      pe(7'h7f, 7'h7f);
      q(1'b0, 0, 32'h4f220f0d);
      q(1'b0, 1, 32'h4f220000);
      q(1'b1, 0, 32'h4f220f0d);
      for (int k = 0; k < 7; k++) begin
         pe(7'h01 << k, 7'h01 << k);
         q(1'b1, 0, emap[k]);
      end
      fw(1'b0, rsb_pkg::FSEL_G1, 8'h01);
      fw(1'b0, rsb_pkg::FSEL_G2, 8'h04);
      fw(1'b0, rsb_pkg::FSEL_G3, 8'h20);
      fw(1'b0, rsb_pkg::FSEL_G4, 8'h08);
      pe(7'h7f, 7'h2a);
      q(1'b0, 0, 32'h08200401);
      q(1'b1, 1, 32'h0a200f0d);
      // Event in the accept cycle shows in the next reply
      fork
         q(1'b1, 0, 32'h0a200000);
         pe(7'h01, 7'h2a);
      join
      q(1'b1, 0, 32'h0a200001);
      wrap_up();
   end
endmodule : rsb_status_bank_test
